//--- logic/mef_pkg.sv
package mef_pkg;
	// register interface widths
	localparam int ADDR_W = 7;
	localparam int DATA_W = 32;
	localparam int NUM_EVENTS = 32;
	localparam int SPI_STATUS_W = 8;
	localparam int DRV_FLAG_W = 8;

	// register addresses
	localparam logic [ADDR_W-1:0] ADDR_STEP_CONF = 7'h0A;
	localparam logic [ADDR_W-1:0] ADDR_SPI_STATUS_SEL = 7'h0B;
	localparam logic [ADDR_W-1:0] ADDR_CLEAR_EXEMPT = 7'h0C;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 7'h0D;
	localparam logic [ADDR_W-1:0] ADDR_EVENTS = 7'h0E;

	// driver flag selection field inside the step configuration word
	localparam int DRV_SEL_LSB = 16;

	// reset values
	localparam logic [DATA_W-1:0] RST_EVENTS = 32'h0000_0000;
	localparam logic [DRV_FLAG_W-1:0] RST_DRV_SEL = 8'hFB;
	localparam logic [DATA_W-1:0] RST_SPI_STATUS_SEL = 32'h8202_9805;
	localparam logic [DATA_W-1:0] RST_CLEAR_EXEMPT = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_IRQ_ENABLE = 32'h0000_0000;

	// velocity and ramp state encodings
	localparam logic [1:0] STATE_ZERO = 2'h0;
	localparam logic [1:0] STATE_POS = 2'h1;
	localparam logic [1:0] STATE_NEG = 2'h2;

	// event bit positions
	localparam int EV_TARGET = 0;
	localparam int EV_POS_COMP = 1;
	localparam int EV_VEL_REACHED = 2;
	localparam int EV_VEL_ZERO = 3;
	localparam int EV_VEL_POS = 4;
	localparam int EV_VEL_NEG = 5;
	localparam int EV_RAMP_CONST = 6;
	localparam int EV_RAMP_ACC = 7;
	localparam int EV_RAMP_DEC = 8;
	localparam int EV_MAX_PHASE = 9;
	localparam int EV_HALT_LOCK = 10;
	localparam int EV_LEFT_SWITCH = 11;
	localparam int EV_RIGHT_SWITCH = 12;
	localparam int EV_LEFT_SOFT = 13;
	localparam int EV_RIGHT_SOFT = 14;
	localparam int EV_HOME_ERROR = 15;
	localparam int EV_POS_CAPTURE = 16;
	localparam int EV_WHOLE_STEP = 17;
	localparam int EV_ENC_FAIL = 18;
	localparam int EV_INDEX = 19;
	localparam int EV_ENC_LATCH = 20;
	localparam int EV_SER_FAULT = 21;
	localparam int EV_CRC_FAIL = 22;
	localparam int EV_SER_RX = 23;
	localparam int EV_DRV_TX = 25;
	localparam int EV_ENC_SPEED_ZERO = 26;
	localparam int EV_ANGLE_MAX = 27;
	localparam int EV_LOOP_TOL = 28;
	localparam int EV_STALL = 29;
	localparam int EV_DRIVER_FLAG = 30;
	localparam int EV_SLEEP = 31;

	// level conditions passed through the rise detector, in this order
	localparam int LVL_W = 12;
endpackage : mef_pkg

//--- logic/mef_rise.sv
`timescale 1ns/10ps
`default_nettype none
module mef_rise
	import mef_pkg::*;
#(
	parameter int W = 1
) (
	clk, // system clock
	rst_n, // synchronised reset, active low
	level, // condition levels
	rise // one-cycle pulse on each rising level
);
	input wire logic clk;
	input wire logic rst_n;
	input wire logic [W-1:0] level;
	output logic [W-1:0] rise;

	logic [W-1:0] prev_reg;
	logic [W-1:0] prev_next;

	// previous levels
	always_comb begin
		prev_next = level;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= prev_next;
		end
	end

	assign rise = level & ~prev_reg;
endmodule : mef_rise
`default_nettype wire

//--- logic/mef_dir_lock.sv
`timescale 1ns/10ps
`default_nettype none
module mef_dir_lock
	import mef_pkg::*;
(
	clk, // system clock
	rst_n, // synchronised reset, active low
	trigger, // stop condition pulse
	event_set, // matching event bit still set
	release_level, // level that allows release
	release_pulse, // strobe that allows release once seen
	blocked // motion in this direction refused
);
	input wire logic clk;
	input wire logic rst_n;
	input wire logic trigger;
	input wire logic event_set;
	input wire logic release_level;
	input wire logic release_pulse;
	output logic blocked;

	logic blocked_reg;
	logic blocked_next;
	logic seen_reg;
	logic seen_next;

	// remember a rewrite seen before the read
	always_comb begin
		blocked_next = blocked_reg;
		seen_next = seen_reg;
		if (trigger) begin
			blocked_next = 1'b1;
			seen_next = 1'b0;
		end else if (blocked_reg) begin
			if (release_pulse) begin
				seen_next = 1'b1;
			end
			if (!event_set && (release_level || seen_reg || release_pulse)) begin
				blocked_next = 1'b0;
				seen_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			blocked_reg <= 1'b0;
			seen_reg <= 1'b0;
		end else begin
			blocked_reg <= blocked_next;
			seen_reg <= seen_next;
		end
	end

	assign blocked = blocked_reg;
endmodule : mef_dir_lock
`default_nettype wire

//--- logic/mef_motion_event_flags.sv
// Operation
// - latch target, position-compare and maximum-velocity reached events
// - latch velocity state becoming zero, positive or negative in bits 3 to 5
// - latch ramp state becoming constant, accelerating or decelerating
// - bit 9 on trapezoid limit speed while velocity above nonzero break velocity
// - bit 10 when halt input goes low; only reset allows motion again
// - bit 11 on left switch; block negative motion until cleared and released
// - right switch event; block positive motion until cleared and released
// - bit 13 left soft limit; block negative until cleared and rewritten or disabled
// - bit 14 right soft limit; block positive until cleared and rewritten or disabled
// - bit 15 on wrong home polarity outside the home margin
// - bit 16 when the captured position register is rewritten
// - latch event when whole-step operation becomes active
// - latch event on encoder position mismatch failure
// - latch index event and encoder latch rewrite as separate bits
// - latch serial sensor fault on multi-cycle or consecutive-request error
// - bit 22 on serial sensor checksum failure
// - latch event on each word received from the serial sensor
// - latch event when a driver datagram has been sent completely
// - latch encoder speed zero and commutation angle maximum events
// - latch event when the loop tolerance flag becomes active
// - stop the motor and latch an event on stall
// - latch driver flag event and sleep timer start event
// - reading events clears them except bits exempted in the exempt mask
// - interrupt output high while any enabled event bit is set
// - selected events are forwarded into eight host status bits
// - selected driver status flags raise the driver event at bit 30
`timescale 1ns/10ps
`default_nettype none
module mef_motion_event_flags
	import mef_pkg::*;
#(
	parameter int VEL_W = 32
) (
	clk, // 100 MHz clock
	resetn, // async reset, low
	reg_addr, // register address
	reg_wr, // write strobe
	reg_rd, // read strobe
	reg_wdata, // write data
	reg_rdata, // read data, next cycle
	target_reached, // at target
	pos_comp_reached, // at compare value
	vel_reached, // at max velocity
	vel_state, // velocity state
	ramp_state, // ramp state
	max_phase, // trapezoid at limit
	actual_velocity, // velocity magnitude
	break_velocity, // break velocity
	halt_lock_input_n, // halt input, low
	left_limit_switch, // left switch
	right_limit_switch, // right switch
	stop_left_en, // left switch enable
	stop_right_en, // right switch enable
	left_soft_limit, // left soft limit hit
	right_soft_limit, // right soft limit hit
	virtual_left_limit_en, // left soft enable
	virtual_right_limit_en, // right soft enable
	left_soft_limit_wr, // left limit rewritten
	right_soft_limit_wr, // right limit rewritten
	actual_position_wr, // position rewritten
	home_wrong_level, // home level wrong
	home_outside_margin, // outside home margin
	position_capture_wr, // capture written
	whole_step_active, // whole-step mode
	encoder_fail, // encoder mismatch
	index_active, // index event
	encoder_latch_wr, // encoder latch written
	multi_cycle_fail, // multi-cycle fault
	consecutive_fail, // consecutive fault
	crc_fail, // checksum fault
	serial_sensor_rx, // sensor word in
	driver_tx_done, // driver datagram out
	encoder_speed_zero, // encoder stopped
	commutation_angle_max, // angle at max
	loop_in_tolerance_flag, // loop in tolerance
	stall_detected, // stall
	driver_status, // driver flags
	sleep_timer_start, // sleep timer start
	irq, // interrupt, high
	spi_status, // host status byte
	block_neg_motion, // negative refused
	block_pos_motion, // positive refused
	halt_lock, // halted until reset
	stop_motor // stall stop
);
	input wire logic clk;
	input wire logic resetn;
	input wire logic [ADDR_W-1:0] reg_addr;
	input wire logic reg_wr;
	input wire logic reg_rd;
	input wire logic [DATA_W-1:0] reg_wdata;
	output logic [DATA_W-1:0] reg_rdata;
	input wire logic target_reached;
	input wire logic pos_comp_reached;
	input wire logic vel_reached;
	input wire logic [1:0] vel_state;
	input wire logic [1:0] ramp_state;
	input wire logic max_phase;
	input wire logic [VEL_W-1:0] actual_velocity;
	input wire logic [VEL_W-1:0] break_velocity;
	input wire logic halt_lock_input_n;
	input wire logic left_limit_switch;
	input wire logic right_limit_switch;
	input wire logic stop_left_en;
	input wire logic stop_right_en;
	input wire logic left_soft_limit;
	input wire logic right_soft_limit;
	input wire logic virtual_left_limit_en;
	input wire logic virtual_right_limit_en;
	input wire logic left_soft_limit_wr;
	input wire logic right_soft_limit_wr;
	input wire logic actual_position_wr;
	input wire logic home_wrong_level;
	input wire logic home_outside_margin;
	input wire logic position_capture_wr;
	input wire logic whole_step_active;
	input wire logic encoder_fail;
	input wire logic index_active;
	input wire logic encoder_latch_wr;
	input wire logic multi_cycle_fail;
	input wire logic consecutive_fail;
	input wire logic crc_fail;
	input wire logic serial_sensor_rx;
	input wire logic driver_tx_done;
	input wire logic encoder_speed_zero;
	input wire logic commutation_angle_max;
	input wire logic loop_in_tolerance_flag;
	input wire logic stall_detected;
	input wire logic [DRV_FLAG_W-1:0] driver_status;
	input wire logic sleep_timer_start;
	output logic irq;
	output logic [SPI_STATUS_W-1:0] spi_status;
	output logic block_neg_motion;
	output logic block_pos_motion;
	output logic halt_lock;
	output logic stop_motor;

	// reset release through two flops; assertion stays asynchronous
	logic rst_sync1_reg;
	logic rst_n;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync1_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_n <= rst_sync1_reg;
		end
	end

	// configuration and event state
	logic [DATA_W-1:0] events_reg;
	logic [DATA_W-1:0] events_next;
	logic [DRV_FLAG_W-1:0] drv_sel_reg;
	logic [DRV_FLAG_W-1:0] drv_sel_next;
	logic [DATA_W-1:0] spi_sel_reg;
	logic [DATA_W-1:0] spi_sel_next;
	logic [DATA_W-1:0] exempt_reg;
	logic [DATA_W-1:0] exempt_next;
	logic [DATA_W-1:0] irq_en_reg;
	logic [DATA_W-1:0] irq_en_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [SPI_STATUS_W-1:0] spi_status_reg;
	logic [SPI_STATUS_W-1:0] spi_status_next;
	logic halt_reg;
	logic halt_next;
	logic stall_stop_reg;
	logic stall_stop_next;

	// level conditions whose rising edge is the event
	logic [LVL_W-1:0] lvl;
	logic [LVL_W-1:0] lvl_rise;
	logic max_phase_cond;
	logic home_cond;

	assign max_phase_cond = max_phase && (break_velocity != '0) &&
		(actual_velocity > break_velocity);
	assign home_cond = home_wrong_level && home_outside_margin;
	assign lvl = {
		stall_detected,
		loop_in_tolerance_flag,
		commutation_angle_max,
		encoder_speed_zero,
		index_active,
		encoder_fail,
		whole_step_active,
		home_cond,
		right_soft_limit,
		left_soft_limit,
		!halt_lock_input_n,
		max_phase_cond
	};

	mef_rise #(.W(LVL_W)) u_lvl_rise (
		.clk(clk),
		.rst_n(rst_n),
		.level(lvl),
		.rise(lvl_rise)
	);

	// reached flags and driver flags
	logic [2:0] flag_rise;
	logic [DRV_FLAG_W-1:0] drv_rise;
	mef_rise #(.W(3)) u_flag_rise (
		.clk(clk),
		.rst_n(rst_n),
		.level({vel_reached, pos_comp_reached, target_reached}),
		.rise(flag_rise)
	);
	mef_rise #(.W(DRV_FLAG_W)) u_drv_rise (
		.clk(clk),
		.rst_n(rst_n),
		.level(driver_status),
		.rise(drv_rise)
	);

	// a disabled switch raises no event
	logic [1:0] sw_rise;
	mef_rise #(.W(2)) u_sw_rise (
		.clk(clk),
		.rst_n(rst_n),
		.level({right_limit_switch && stop_right_en, left_limit_switch && stop_left_en}),
		.rise(sw_rise)
	);

	// event when a state newly takes a value
	logic [1:0] vel_prev_reg;
	logic [1:0] ramp_prev_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vel_prev_reg <= STATE_ZERO;
			ramp_prev_reg <= STATE_ZERO;
		end else begin
			vel_prev_reg <= vel_state;
			ramp_prev_reg <= ramp_state;
		end
	end

	// gather all set requests into one word
	logic [DATA_W-1:0] set_vec;
	always_comb begin
		set_vec = '0;
		set_vec[EV_TARGET] = flag_rise[0];
		set_vec[EV_POS_COMP] = flag_rise[1];
		set_vec[EV_VEL_REACHED] = flag_rise[2];
		set_vec[EV_VEL_ZERO] = (vel_state != vel_prev_reg) && (vel_state == STATE_ZERO);
		set_vec[EV_VEL_POS] = (vel_state != vel_prev_reg) && (vel_state == STATE_POS);
		set_vec[EV_VEL_NEG] = (vel_state != vel_prev_reg) && (vel_state == STATE_NEG);
		set_vec[EV_RAMP_CONST] = (ramp_state != ramp_prev_reg) && (ramp_state == STATE_ZERO);
		set_vec[EV_RAMP_ACC] = (ramp_state != ramp_prev_reg) && (ramp_state == STATE_POS);
		set_vec[EV_RAMP_DEC] = (ramp_state != ramp_prev_reg) && (ramp_state == STATE_NEG);
		set_vec[EV_MAX_PHASE] = lvl_rise[0];
		set_vec[EV_HALT_LOCK] = lvl_rise[1];
		set_vec[EV_LEFT_SWITCH] = sw_rise[0];
		set_vec[EV_RIGHT_SWITCH] = sw_rise[1];
		set_vec[EV_LEFT_SOFT] = lvl_rise[2] && virtual_left_limit_en;
		set_vec[EV_RIGHT_SOFT] = lvl_rise[3] && virtual_right_limit_en;
		set_vec[EV_HOME_ERROR] = lvl_rise[4];
		set_vec[EV_POS_CAPTURE] = position_capture_wr;
		set_vec[EV_WHOLE_STEP] = lvl_rise[5];
		set_vec[EV_ENC_FAIL] = lvl_rise[6];
		set_vec[EV_INDEX] = lvl_rise[7];
		set_vec[EV_ENC_LATCH] = encoder_latch_wr;
		set_vec[EV_SER_FAULT] = multi_cycle_fail || consecutive_fail;
		set_vec[EV_CRC_FAIL] = crc_fail;
		set_vec[EV_SER_RX] = serial_sensor_rx;
		set_vec[EV_DRV_TX] = driver_tx_done;
		set_vec[EV_ENC_SPEED_ZERO] = lvl_rise[8];
		set_vec[EV_ANGLE_MAX] = lvl_rise[9];
		set_vec[EV_LOOP_TOL] = lvl_rise[10];
		set_vec[EV_STALL] = lvl_rise[11];
		set_vec[EV_DRIVER_FLAG] = |(drv_rise & drv_sel_reg);
		set_vec[EV_SLEEP] = sleep_timer_start;
	end

	// direction locks; virtual limits release on a rewrite or when disabled
	logic [3:0] lock_trig;
	logic [3:0] lock_ev;
	logic [3:0] lock_lvl;
	logic [3:0] lock_pulse;
	logic [3:0] lock_out;
	assign lock_trig = {set_vec[EV_RIGHT_SOFT], set_vec[EV_LEFT_SOFT],
		set_vec[EV_RIGHT_SWITCH], set_vec[EV_LEFT_SWITCH]};
	assign lock_ev = {events_reg[EV_RIGHT_SOFT], events_reg[EV_LEFT_SOFT],
		events_reg[EV_RIGHT_SWITCH], events_reg[EV_LEFT_SWITCH]};
	assign lock_lvl = {!virtual_right_limit_en, !virtual_left_limit_en,
		!right_limit_switch || !stop_right_en, !left_limit_switch || !stop_left_en};
	assign lock_pulse = {right_soft_limit_wr || actual_position_wr,
		left_soft_limit_wr || actual_position_wr, 2'b00};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lock
			mef_dir_lock u_lock (
				.clk(clk),
				.rst_n(rst_n),
				.trigger(lock_trig[gi]),
				.event_set(lock_ev[gi]),
				.release_level(lock_lvl[gi]),
				.release_pulse(lock_pulse[gi]),
				.blocked(lock_out[gi])
			);
		end
	endgenerate

	assign block_neg_motion = lock_out[0] || lock_out[2] || halt_reg || stall_stop_reg;
	assign block_pos_motion = lock_out[1] || lock_out[3] || halt_reg || stall_stop_reg;

	// register access: a set in the read cycle survives the clear
	always_comb begin
		events_next = events_reg | set_vec;
		drv_sel_next = drv_sel_reg;
		spi_sel_next = spi_sel_reg;
		exempt_next = exempt_reg;
		irq_en_next = irq_en_reg;
		rdata_next = rdata_reg;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_STEP_CONF: rdata_next = {{(DATA_W-DRV_SEL_LSB-DRV_FLAG_W){1'b0}},
					drv_sel_reg, {DRV_SEL_LSB{1'b0}}};
				ADDR_SPI_STATUS_SEL: rdata_next = spi_sel_reg;
				ADDR_CLEAR_EXEMPT: rdata_next = exempt_reg;
				ADDR_IRQ_ENABLE: rdata_next = irq_en_reg;
				ADDR_EVENTS: begin
					rdata_next = events_reg;
					events_next = (events_reg & exempt_reg) | set_vec;
				end
				default: rdata_next = '0;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				ADDR_STEP_CONF: drv_sel_next = reg_wdata[DRV_SEL_LSB +: DRV_FLAG_W];
				ADDR_SPI_STATUS_SEL: spi_sel_next = reg_wdata;
				ADDR_CLEAR_EXEMPT: exempt_next = reg_wdata;
				ADDR_IRQ_ENABLE: irq_en_next = reg_wdata;
				default: ;
			endcase
		end
	end

	// lowest selected events fill the status byte from bit 0
	always_comb begin
		int slot;
		slot = 0;
		spi_status_next = '0;
		for (int i = 0; i < NUM_EVENTS; i++) begin
			if (spi_sel_reg[i] && slot < SPI_STATUS_W) begin
				spi_status_next[slot[2:0]] = events_next[i];
				slot = slot + 1;
			end
		end
	end

	// halt holds until reset; stall stop falls with its event bit
	always_comb begin
		halt_next = halt_reg || set_vec[EV_HALT_LOCK];
		stall_stop_next = set_vec[EV_STALL] || (stall_stop_reg && events_reg[EV_STALL]);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			events_reg <= RST_EVENTS;
			drv_sel_reg <= RST_DRV_SEL;
			spi_sel_reg <= RST_SPI_STATUS_SEL;
			exempt_reg <= RST_CLEAR_EXEMPT;
			irq_en_reg <= RST_IRQ_ENABLE;
			rdata_reg <= '0;
			spi_status_reg <= '0;
			halt_reg <= 1'b0;
			stall_stop_reg <= 1'b0;
		end else begin
			events_reg <= events_next;
			drv_sel_reg <= drv_sel_next;
			spi_sel_reg <= spi_sel_next;
			exempt_reg <= exempt_next;
			irq_en_reg <= irq_en_next;
			rdata_reg <= rdata_next;
			spi_status_reg <= spi_status_next;
			halt_reg <= halt_next;
			stall_stop_reg <= stall_stop_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign spi_status = spi_status_reg;
	assign irq = |(events_reg & irq_en_reg);
	assign halt_lock = halt_reg;
	assign stop_motor = stall_stop_reg;
endmodule : mef_motion_event_flags
`default_nettype wire

//--- dv/mef_host.sv
`timescale 1ns/10ps
`default_nettype none
module mef_host
	import mef_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic [DATA_W-1:0] reg_rdata, // read data from the block
	output logic [ADDR_W-1:0] reg_addr, // register address
	output logic reg_wr, // write strobe
	output logic reg_rd, // read strobe
	output logic [DATA_W-1:0] reg_wdata // write data
);
	// bus idle; tasks start just after an edge
	initial begin
		reg_addr = 7'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h0000_0000;
	end

	// one write, then an idle cycle
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		@(posedge clk);
		#1;
	endtask : wr

	// one or two back-to-back reads
	task automatic rd(input logic [ADDR_W-1:0] a, input int n, output logic [DATA_W-1:0] d0,
		output logic [DATA_W-1:0] d1);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		d0 = reg_rdata;
		d1 = d0;
		if (n > 1) begin
			@(posedge clk);
			#1;
			d1 = reg_rdata;
		end
		reg_rd = 1'b0;
		@(posedge clk);
		#1;
	endtask : rd
endmodule : mef_host
`default_nettype wire

//--- dv/mef_chk.sv
`timescale 1ns/10ps
`default_nettype none
module mef_chk
	import mef_pkg::*;
(
	input wire logic clk, // clock
	input wire logic resetn, // reset, active low
	input wire logic [ADDR_W-1:0] reg_addr, // address
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [DATA_W-1:0] reg_wdata, // write data
	input wire logic [DATA_W-1:0] reg_rdata, // read data
	input wire logic crc_fail, // checksum fault
	input wire logic halt_lock_input_n, // halt input
	input wire logic stall_detected, // stall
	input wire logic left_limit_switch, // left switch
	input wire logic right_limit_switch, // right switch
	input wire logic stop_left_en, // left enable
	input wire logic stop_right_en, // right enable
	input wire logic irq, // interrupt
	input wire logic block_neg_motion, // negative refused
	input wire logic block_pos_motion, // positive refused
	input wire logic halt_lock, // halt held
	input wire logic stop_motor // stall stop held
);
	logic [1:0] sync_reg;
	logic [DATA_W-1:0] irq_mask_reg;
	logic [DATA_W-1:0] exempt_reg;
	logic rst_ok;
	logic rd_ev;

	// mirror the two-flop reset release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync_reg <= 2'h0;
			irq_mask_reg <= 32'h0000_0000;
			exempt_reg <= 32'h0000_0000;
		end else begin
			sync_reg <= {sync_reg[0], 1'b1};
			if (reg_wr && reg_addr == ADDR_IRQ_ENABLE) irq_mask_reg <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_CLEAR_EXEMPT) exempt_reg <= reg_wdata;
		end
	end
	assign rst_ok = sync_reg[1];
	assign rd_ev = reg_rd && reg_addr == ADDR_EVENTS;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_ok);

	a_halt_sets_lock: assert property ($fell(halt_lock_input_n) |=> halt_lock)
		else $error("halt input fall did not set halt lock");
	a_halt_blocks_both: assert property (halt_lock |-> ##[0:1] (block_neg_motion && block_pos_motion))
		else $error("halt lock without both directions blocked");
	a_stall_stops: assert property ($rose(stall_detected) |-> ##[1:2] (stop_motor && block_pos_motion))
		else $error("stall did not stop the motor");
	a_left_switch_lock: assert property ($rose(left_limit_switch) && stop_left_en |-> ##[1:2] block_neg_motion)
		else $error("left switch did not block negative motion");
	a_right_switch_lock: assert property ($rose(right_limit_switch) && stop_right_en |-> ##[1:2] block_pos_motion)
		else $error("right switch did not block positive motion");
	a_crc_irq: assert property (crc_fail && irq_mask_reg[EV_CRC_FAIL] |=> irq)
		else $error("enabled checksum event raised no interrupt");
	a_crc_read_sets: assert property (crc_fail ##1 rd_ev |=> reg_rdata[EV_CRC_FAIL])
		else $error("checksum event missing from read");
	a_read_clears_bit: assert property (rd_ev && !exempt_reg[EV_CRC_FAIL] && !crc_fail ##1 rd_ev
		|=> !reg_rdata[EV_CRC_FAIL])
		else $error("read did not clear checksum event");
	a_exempt_keeps_bit: assert property (rd_ev && exempt_reg[EV_CRC_FAIL] ##1 (rd_ev && reg_rdata[EV_CRC_FAIL])
		|=> reg_rdata[EV_CRC_FAIL])
		else $error("exempt event lost on read");

	// main scenarios reached
	c_halt: cover property ($rose(halt_lock));
	c_stall: cover property ($rose(stop_motor));
	c_exempt: cover property (rd_ev && exempt_reg[EV_CRC_FAIL] ##1 rd_ev);
endmodule : mef_chk

bind mef_motion_event_flags mef_chk chk_u (
	.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .crc_fail(crc_fail),
	.halt_lock_input_n(halt_lock_input_n), .stall_detected(stall_detected),
	.left_limit_switch(left_limit_switch), .right_limit_switch(right_limit_switch),
	.stop_left_en(stop_left_en), .stop_right_en(stop_right_en), .irq(irq),
	.block_neg_motion(block_neg_motion), .block_pos_motion(block_pos_motion),
	.halt_lock(halt_lock), .stop_motor(stop_motor)
);
`default_nettype wire

//--- dv/motion_event_flags_test.sv
`timescale 1ns/10ps
`default_nettype none
module motion_event_flags_test;
	import mef_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	int n_errors = 0;
	int compares = 0;
	// condition sources indexed by event bit; 40..43 enables, 44..46 rewrite pulses
	logic [46:0] src = 47'h0F00_0000_0000;
	logic [1:0] vel_state = 2'h0;
	logic [1:0] ramp_state = 2'h0;
	logic [ADDR_W-1:0] reg_addr;
	logic reg_wr, reg_rd, irq, block_neg, block_pos, halt_lock, stop_motor;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, d, e;
	logic [SPI_STATUS_W-1:0] spi_status;

	always #5 clk = ~clk;

	mef_host host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata));

	// both home inputs share one source
	mef_motion_event_flags dut_u (
		.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .target_reached(src[0]),
		.pos_comp_reached(src[1]), .vel_reached(src[2]), .vel_state(vel_state),
		.ramp_state(ramp_state), .max_phase(src[9]), .actual_velocity(32'h0000_0006),
		.break_velocity(32'h0000_0005), .halt_lock_input_n(~src[10]),
		.left_limit_switch(src[11]), .right_limit_switch(src[12]), .stop_left_en(src[40]),
		.stop_right_en(src[41]), .left_soft_limit(src[13]), .right_soft_limit(src[14]),
		.virtual_left_limit_en(src[42]), .virtual_right_limit_en(src[43]),
		.left_soft_limit_wr(src[44]), .right_soft_limit_wr(src[45]),
		.actual_position_wr(src[46]), .home_wrong_level(src[15]), .home_outside_margin(src[15]),
		.position_capture_wr(src[16]), .whole_step_active(src[17]), .encoder_fail(src[18]),
		.index_active(src[19]), .encoder_latch_wr(src[20]), .multi_cycle_fail(src[21]),
		.consecutive_fail(src[24]), .crc_fail(src[22]), .serial_sensor_rx(src[23]),
		.driver_tx_done(src[25]), .encoder_speed_zero(src[26]), .commutation_angle_max(src[27]),
		.loop_in_tolerance_flag(src[28]), .stall_detected(src[29]),
		.driver_status({src[38:32], src[30]}), .sleep_timer_start(src[31]), .irq(irq),
		.spi_status(spi_status), .block_neg_motion(block_neg), .block_pos_motion(block_pos),
		.halt_lock(halt_lock), .stop_motor(stop_motor)
	);

	task automatic step(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, m, seen, exp);
		end
	endtask : check

	// status bit of event k under the default selection
	function automatic logic [31:0] exp_spi(input int k);
		return RST_SPI_STATUS_SEL[k] ?
			32'h1 << $countones(RST_SPI_STATUS_SEL & ((32'h1 << k) - 1)) : 32'h0;
	endfunction : exp_spi

	task automatic t_regs;
		host_u.wr(ADDR_EVENTS, 32'hFFFF_FFFF);
		host_u.rd(ADDR_EVENTS, 1, d, e);
		check(d, 32'h0000_0000, "events reset or written");
		host_u.rd(ADDR_STEP_CONF, 1, d, e);
		check(d, 32'h00FB_0000, "driver select reset");
		host_u.rd(7'h7F, 1, d, e);
		check(d, 32'h0000_0000, "unmapped read");
		$display("test regs done");
	endtask : t_regs

	task automatic t_locks;
		src[14:11] = 4'hF;
		step(3);
		check(32'({block_neg, block_pos}), 32'h3, "both locks");
		host_u.rd(ADDR_EVENTS, 1, d, e);
		check(d, 32'h0000_7800, "lock events kept");
		src[11] = 1'b0;
		step(3);
		check(32'(block_neg), 32'h1, "soft lock holds");
		src[46] = 1'b1;
		step(1);
		src[46] = 1'b0;
		step(3);
		check(32'(block_neg), 32'h0, "negative released");
		src[41] = 1'b0;
		src[45] = 1'b1;
		step(1);
		src[45] = 1'b0;
		step(3);
		check(32'(block_pos), 32'h0, "positive released");
		src[14:12] = 3'h0;
		step(1);
		src[41] = 1'b1;
		$display("test locks done");
	endtask : t_locks

	task automatic t_exempt;
		host_u.wr(ADDR_CLEAR_EXEMPT, 32'h0040_0000);
		src[22] = 1'b1;
		step(1);
		src[22] = 1'b0;
		host_u.rd(ADDR_EVENTS, 2, d, e);
		check(e, 32'h0040_0000, "exempt bit survives");
		host_u.wr(ADDR_CLEAR_EXEMPT, 32'h0000_0000);
		host_u.rd(ADDR_EVENTS, 2, d, e);
		check({d[23:0], 8'h00} | e, 32'h4000_0000, "read clears");
		$display("test exempt done");
	endtask : t_exempt

	task automatic t_events;
		int k;
		host_u.wr(ADDR_IRQ_ENABLE, 32'hFFFF_FFFF);
		vel_state = 2'h2;
		ramp_state = 2'h2;
		step(2);
		host_u.rd(ADDR_EVENTS, 1, d, e);
		for (int b = 0; b < 32; b++) begin
			if (b == 10) continue;
			k = (b == 24) ? 21 : b;
			if (b >= 3 && b < 6) vel_state = 2'(b - 3);
			if (b >= 6 && b < 9) ramp_state = 2'(b - 6);
			src[b] = 1'b1;
			step(1);
			src[b] = 1'b0;
			step(1);
			check(32'(irq), 32'h1, "irq raised");
			check(32'(spi_status), exp_spi(k), "status bits");
			host_u.rd(ADDR_EVENTS, 1, d, e);
			check(d, 32'h1 << k, "single event bit");
			check(32'(irq), 32'h0, "irq cleared");
		end
		src[33] = 1'b1;
		step(1);
		src[33] = 1'b0;
		host_u.rd(ADDR_EVENTS, 1, d, e);
		check(d, 32'h0000_0000, "unselected driver flag");
		$display("test events done");
	endtask : t_events

	task automatic t_halt;
		src[10] = 1'b1;
		step(3);
		check(32'({halt_lock, block_neg, block_pos}), 32'h7, "halt locks");
		host_u.rd(ADDR_EVENTS, 1, d, e);
		check(d, 32'h0000_0400, "halt event");
		src[10] = 1'b0;
		step(3);
		check(32'(halt_lock), 32'h1, "halt survives input");
		resetn = 1'b0;
		step(4);
		resetn = 1'b1;
		step(3);
		check(32'(halt_lock), 32'h0, "reset ends halt");
		$display("test halt done");
	endtask : t_halt

	task automatic finish_test;
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	// four reset cycles, three for the internal release
	initial begin
		step(4);
		resetn = 1'b1;
		step(3);
		t_regs();
		t_locks();
		t_exempt();
		t_events();
		t_halt();
		finish_test();
	end

	// a hang ends here
	initial begin
		#200_000;
		n_errors++;
		finish_test();
	end
endmodule : motion_event_flags_test
`default_nettype wire
